//--- logic/dcr_consts.svh
// Contract
// RL1 - channel moves data only while channel_on is set
// RL2 - size bit set moves bytes, clear moves 16-bit words
// RL3 - direction set: RAM to peripheral; clear: peripheral to RAM
// RL4 - block event at half block if half set, else at full block
// RL5 - dummy write adds null peripheral write when direction clear
// RL6 - addressing_style 00 post-inc, 01 no inc, 10 peripheral, 11 reserved
// RL7 - mode: 00 cont, 01 one-shot, 10 cont ping-pong, 11 one-shot ping-pong
// RL8 - force bit starts exactly one manual transfer
// RL9 - force not cleared by software; cleared on completion or channel off
// RL10 - trigger_source_select picks the request number that starts transfers
// RL11 - unimplemented bits read as zero
// RL12 - first buffer base is 24 bits over high and low registers
// RL13 - second buffer base is 24 bits over high and low registers
// RL14 - peripheral address register holds 16-bit peripheral address
// RL15 - transfer_tally is 14 bits, bits 15-14 read zero
// RL16 - all implemented bits reset to zero
// RL17 - block ends after tally plus one transfers
// RL18 - base address reads return latest transfer address
// RL19 - software avoids rewriting addresses or count while enabled
// RL20 - post-increment adds one per byte, two per word
// RL21 - block end reloads, ping-pong swaps buffer, one-shot disables
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH
`define DCR_OFF_CTRL 8'h00
`define DCR_OFF_REQ 8'h04
`define DCR_OFF_STAH 8'h08
`define DCR_OFF_STAL 8'h0C
`define DCR_OFF_STBH 8'h10
`define DCR_OFF_STBL 8'h14
`define DCR_OFF_PAD 8'h18
`define DCR_OFF_CNT 8'h1C
`define DCR_CTRL_MASK 16'hF833
`define DCR_HI_MASK 16'h00FF
`define DCR_CNT_MASK 16'h3FFF
`define DCR_B_ON 15
`define DCR_B_SIZE 14
`define DCR_B_DIR 13
`define DCR_B_HALF 12
`define DCR_B_DUMMY_PERIPHERAL_WRITE 11
`define DCR_B_FORCE 15
`define DCR_AM_HI 5
`define DCR_AM_LO 4
`define DCR_AM_POST 2'h0
`define DCR_AM_PIA 2'h2
`define DCR_MODE_ONESHOT 0
`define DCR_MODE_PP 1
`define DCR_STEP_BYTE 24'h000001
`define DCR_STEP_WORD 24'h000002
`define DCR_ZERO8 8'h00
`define DCR_ZERO16 16'h0000
`define DCR_ZERO24 24'h000000
`define DCR_ZERO14 14'h0000
`endif

//--- logic/dcr_pkg.sv
package dcr_pkg;
  typedef enum logic [2:0] {
    DCR_I_CTRL = 3'h0, DCR_I_REQ = 3'h1, DCR_I_STAH = 3'h2,
    DCR_I_STAL = 3'h3, DCR_I_STBH = 3'h4, DCR_I_STBL = 3'h5,
    DCR_I_PAD = 3'h6, DCR_I_CNT = 3'h7
  } dcr_idx_t;
  typedef enum logic [0:0] {
    DCR_IDLE = 1'b0,
    DCR_BUSY = 1'b1
  } dcr_fsm_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic force_on;
    logic [7:0] trigger_source_select;
    logic [23:0] first_buffer_base;
    logic [23:0] stb;
    logic [15:0] pad;
    logic [13:0] cnt;
    logic [23:0] last_a;
    logic [23:0] last_b;
    logic [23:0] cur;
    logic [13:0] done_n;
    logic buf_b;
    logic pend;
    logic forced;
    dcr_fsm_t st;
    logic req;
    logic [23:0] rda;
    logic [23:0] wra;
    logic byt;
    logic dummy_peripheral_write;
    logic evt;
    logic [15:0] rdata;
  } dcr_state_t;
endpackage

//--- logic/dcr_apb_dec.sv
`include "dcr_consts.svh"
module dcr_apb_dec
  import dcr_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  output dcr_idx_t idx,
  output logic hit,
  output logic wr_en,
  output logic rd_setup
);
  function automatic logic match(input logic [7:0] a);
    match = (a == `DCR_OFF_CTRL) || (a == `DCR_OFF_REQ) ||
      (a == `DCR_OFF_STAH) || (a == `DCR_OFF_STAL) ||
      (a == `DCR_OFF_STBH) || (a == `DCR_OFF_STBL) ||
      (a == `DCR_OFF_PAD) || (a == `DCR_OFF_CNT);
  endfunction
  always_comb
  begin
    idx = dcr_idx_t'(paddr[4:2]);
    hit = match(paddr);
    wr_en = psel && penable && pwrite && hit;
    rd_setup = psel && !penable && !pwrite;
  end
endmodule // dcr_apb_dec

//--- logic/dcr_addr_step.sv
`include "dcr_consts.svh"
module dcr_addr_step
  import dcr_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic byte_mode,
  output logic [23:0] next_addr
);
  // advance one per byte, two per word
  always_comb
  begin
    next_addr = addr + (byte_mode ? `DCR_STEP_BYTE : `DCR_STEP_WORD); // see RL20
  end
endmodule // dcr_addr_step

//--- logic/dcr_channel.sv
`include "dcr_consts.svh"
module dcr_channel
  import dcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_valid,
  input wire logic [7:0] trig_num,
  input wire logic [23:0] pia_addr,
  input wire logic xfer_done,
  output logic xfer_req,
  output logic [23:0] xfer_rd_addr,
  output logic [23:0] xfer_wr_addr,
  output logic xfer_byte,
  output logic xfer_null_wr,
  output logic block_event,
  output logic channel_active
);
  dcr_state_t s_q;
  dcr_state_t s_d;
  dcr_idx_t idx;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic [23:0] cur_next;
  logic [23:0] ram_now;
  logic [23:0] lat;
  logic was_on;
  logic blk_end;
  logic half_pt;
  logic force_wr;

  dcr_apb_dec u_dec (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .idx(idx),
    .hit(hit),
    .wr_en(wr_en),
    .rd_setup(rd_setup)
  );

  dcr_addr_step u_step (
    .addr(s_q.cur),
    .byte_mode(s_q.ctrl[`DCR_B_SIZE]),
    .next_addr(cur_next)
  );

  function automatic logic [23:0] ram_sel(input logic [1:0] am,
                                          input logic [23:0] cur,
                                          input logic [23:0] pia);
    ram_sel = (am == `DCR_AM_PIA) ? pia : cur; // see RL6
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = {`DCR_ZERO16, s_q.rdata};
  assign xfer_req = s_q.req;
  assign xfer_rd_addr = s_q.rda;
  assign xfer_wr_addr = s_q.wra;
  assign xfer_byte = s_q.byt;
  assign xfer_null_wr = s_q.dummy_peripheral_write;
  assign block_event = s_q.evt;
  assign channel_active = s_q.ctrl[`DCR_B_ON];
  assign force_wr = wr_en && idx == DCR_I_REQ && pwdata[`DCR_B_FORCE];

  always_comb
  begin
    s_d = s_q;
    s_d.evt = 1'b0;
    was_on = s_q.ctrl[`DCR_B_ON];
    ram_now = ram_sel(s_q.ctrl[`DCR_AM_HI:`DCR_AM_LO], s_q.cur, pia_addr);
    lat = s_q.ctrl[`DCR_B_DIR] ? s_q.rda : s_q.wra;
    blk_end = (s_q.done_n == s_q.cnt); // see RL17
    half_pt = (s_q.done_n == {1'b0, s_q.cnt[13:1]});
    if (wr_en)
    begin
      case (idx)
        DCR_I_CTRL:
        begin
          s_d.ctrl = pwdata[15:0] & `DCR_CTRL_MASK; // see RL11
          if (pwdata[`DCR_B_ON] && !was_on)
          begin
            s_d.cur = s_q.first_buffer_base;
            s_d.done_n = `DCR_ZERO14;
            s_d.buf_b = 1'b0;
          end
        end
        DCR_I_REQ:
        begin
          s_d.trigger_source_select = pwdata[7:0]; // see RL10
          if (pwdata[`DCR_B_FORCE])
          begin
            s_d.force_on = 1'b1; // see RL9
          end
        end
        DCR_I_STAH:
        begin
          s_d.first_buffer_base[23:16] = pwdata[7:0]; // see RL12
          s_d.last_a[23:16] = pwdata[7:0];
        end
        DCR_I_STAL:
        begin
          s_d.first_buffer_base[15:0] = pwdata[15:0]; // see RL12
          s_d.last_a[15:0] = pwdata[15:0];
        end
        DCR_I_STBH:
        begin
          s_d.stb[23:16] = pwdata[7:0]; // see RL13
          s_d.last_b[23:16] = pwdata[7:0];
        end
        DCR_I_STBL:
        begin
          s_d.stb[15:0] = pwdata[15:0]; // see RL13
          s_d.last_b[15:0] = pwdata[15:0];
        end
        DCR_I_PAD:
        begin
          s_d.pad = pwdata[15:0]; // see RL14
        end
        DCR_I_CNT:
        begin
          s_d.cnt = pwdata[13:0]; // see RL15
        end
        default:
        begin
          s_d.pad = s_q.pad;
        end
      endcase
    end
    case (s_q.st)
      DCR_IDLE:
      begin
        if (s_q.ctrl[`DCR_B_ON] && (s_q.force_on || s_q.pend)) // see RL1
        begin
          s_d.st = DCR_BUSY;
          s_d.req = 1'b1;
          s_d.forced = s_q.force_on; // see RL8
          if (!s_q.force_on)
          begin
            s_d.pend = 1'b0;
          end
          if (s_q.ctrl[`DCR_B_DIR]) // see RL3
          begin
            s_d.rda = ram_now;
            s_d.wra = {`DCR_ZERO8, s_q.pad};
          end
          else
          begin
            s_d.rda = {`DCR_ZERO8, s_q.pad};
            s_d.wra = ram_now;
          end
          s_d.byt = s_q.ctrl[`DCR_B_SIZE]; // see RL2
          s_d.dummy_peripheral_write = s_q.ctrl[`DCR_B_DUMMY_PERIPHERAL_WRITE] && !s_q.ctrl[`DCR_B_DIR]; // see RL5
        end
      end
      DCR_BUSY:
      begin
        if (xfer_done)
        begin
          s_d.st = DCR_IDLE;
          s_d.req = 1'b0;
          if (s_q.forced)
          begin
            s_d.force_on = force_wr; // see RL9
          end
          if (s_q.buf_b)
          begin
            s_d.last_b = lat; // see RL18
          end
          else
          begin
            s_d.last_a = lat; // see RL18
          end
          if (s_q.ctrl[`DCR_AM_HI:`DCR_AM_LO] == `DCR_AM_POST)
          begin
            s_d.cur = cur_next; // see RL20
          end
          s_d.done_n = s_q.done_n + 14'h0001;
          s_d.evt = s_q.ctrl[`DCR_B_HALF] ? half_pt : blk_end; // see RL4
          if (blk_end)
          begin
            s_d.done_n = `DCR_ZERO14; // see RL21
            if (s_q.ctrl[`DCR_MODE_PP]) // see RL7
            begin
              s_d.buf_b = !s_q.buf_b;
              s_d.cur = s_q.buf_b ? s_q.first_buffer_base : s_q.stb;
            end
            else
            begin
              s_d.cur = s_q.first_buffer_base;
            end
            if (s_q.ctrl[`DCR_MODE_ONESHOT] &&
                (!s_q.ctrl[`DCR_MODE_PP] || s_q.buf_b))
            begin
              s_d.ctrl[`DCR_B_ON] = 1'b0; // see RL21
            end
          end
        end
      end
      default:
      begin
        s_d.st = DCR_IDLE;
        s_d.req = 1'b0;
      end
    endcase
    if (trig_valid && trig_num == s_q.trigger_source_select && s_q.ctrl[`DCR_B_ON])
    begin
      s_d.pend = 1'b1; // see RL10
    end
    if (!s_d.ctrl[`DCR_B_ON])
    begin
      s_d.force_on = 1'b0; // see RL9
      s_d.pend = 1'b0;
    end
    if (rd_setup)
    begin
      case (idx)
        DCR_I_CTRL: s_d.rdata = s_q.ctrl;
        DCR_I_REQ: s_d.rdata = {s_q.force_on, 7'h00, s_q.trigger_source_select}; // see RL11
        DCR_I_STAH: s_d.rdata = {`DCR_ZERO8, s_q.last_a[23:16]}; // see RL18
        DCR_I_STAL: s_d.rdata = s_q.last_a[15:0];
        DCR_I_STBH: s_d.rdata = {`DCR_ZERO8, s_q.last_b[23:16]};
        DCR_I_STBL: s_d.rdata = s_q.last_b[15:0];
        DCR_I_PAD: s_d.rdata = s_q.pad;
        DCR_I_CNT: s_d.rdata = {2'h0, s_q.cnt}; // see RL15
        default: s_d.rdata = `DCR_ZERO16;
      endcase
      if (!hit)
      begin
        s_d.rdata = `DCR_ZERO16;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0; // see RL16
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start_on;
    $rose(xfer_req) |-> $past(s_q.ctrl[`DCR_B_ON]);
  endproperty
  a_start_on: assert property (p_start_on) // see RL1
    else $error("transfer started with channel off");

  property p_size;
    $rose(xfer_req) |-> xfer_byte == $past(s_q.ctrl[`DCR_B_SIZE]);
  endproperty
  a_size: assert property (p_size) // see RL2
    else $error("transfer size mismatch");

  property p_dir;
    $rose(xfer_req) && $past(s_q.ctrl[`DCR_B_DIR])
      |-> xfer_wr_addr == {`DCR_ZERO8, $past(s_q.pad)};
  endproperty
  a_dir: assert property (p_dir) // see RL3
    else $error("peripheral not the destination");

  property p_full_evt;
    xfer_req && xfer_done && !s_q.ctrl[`DCR_B_HALF] &&
      s_q.done_n == s_q.cnt |=> block_event;
  endproperty
  a_full_evt: assert property (p_full_evt) // see RL4
    else $error("missing block event");

  property p_dummy_peripheral_write;
    $rose(xfer_req) |-> xfer_null_wr ==
      ($past(s_q.ctrl[`DCR_B_DUMMY_PERIPHERAL_WRITE]) && !$past(s_q.ctrl[`DCR_B_DIR]));
  endproperty
  a_dummy_peripheral_write: assert property (p_dummy_peripheral_write) // see RL5
    else $error("null write flag wrong");

  property p_force_hold;
    wr_en && idx == DCR_I_REQ && !pwdata[`DCR_B_FORCE] && s_q.force_on &&
      s_q.ctrl[`DCR_B_ON] && !(xfer_req && xfer_done) |=> s_q.force_on;
  endproperty
  a_force_hold: assert property (p_force_hold) // see RL9
    else $error("software cleared force");

  property p_step;
    xfer_req && xfer_done && s_q.done_n != s_q.cnt &&
      s_q.ctrl[`DCR_AM_HI:`DCR_AM_LO] == `DCR_AM_POST
      |=> s_q.cur == $past(s_q.cur) +
        ($past(s_q.ctrl[`DCR_B_SIZE]) ? `DCR_STEP_BYTE : `DCR_STEP_WORD);
  endproperty
  a_step: assert property (p_step) // see RL20
    else $error("post-increment step wrong");

  property p_ctrl_zero;
    rd_setup && idx == DCR_I_CTRL |=> ##1
      (prdata[15:0] & ~`DCR_CTRL_MASK) == `DCR_ZERO16;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) // see RL11
    else $error("unimplemented bits nonzero");

  c_block: cover property (block_event);
  c_forced: cover property (xfer_req && xfer_done && s_q.forced);
  c_pingpong: cover property ($rose(s_q.buf_b));
  c_half: cover property (block_event && s_q.ctrl[`DCR_B_HALF]);

  property p_off_idle;
    !channel_active && !xfer_req |=> !xfer_req;
  endproperty
  a_off_idle: assert property (p_off_idle) // see RL1
    else $error("transfer requested while channel off");

  property p_force_clear;
    xfer_req && xfer_done && s_q.forced && !force_wr |=> !s_q.force_on;
  endproperty
  a_force_clear: assert property (p_force_clear) // see RL9
    else $error("force not cleared after its transfer");

  property p_one_shot_off;
    xfer_req && xfer_done && s_q.done_n == s_q.cnt &&
      s_q.ctrl[`DCR_MODE_ONESHOT] && (!s_q.ctrl[`DCR_MODE_PP] || s_q.buf_b)
      |=> !channel_active;
  endproperty
  a_one_shot_off: assert property (p_one_shot_off) // see RL21
    else $error("one-shot channel still on after block");

  property p_pp_swap;
    xfer_req && xfer_done && s_q.done_n == s_q.cnt &&
      s_q.ctrl[`DCR_MODE_PP] && !s_q.buf_b
      |=> s_q.buf_b && s_q.cur == $past(s_q.stb);
  endproperty
  a_pp_swap: assert property (p_pp_swap) // see RL21
    else $error("ping-pong did not switch to second buffer");
endmodule // dcr_channel

//--- verif/dcr_far_model.sv
module dcr_far_model
  import dcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_req,
  input wire logic [3:0] lat,
  output logic xfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic held_q;
  // one done pulse per request, lat cycles after it is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 4'h0;
      held_q <= 1'b0;
      xfer_done <= 1'b0;
    end
    else if (!xfer_req)
    begin
      wait_q <= 4'h0;
      held_q <= 1'b0;
      xfer_done <= 1'b0;
    end
    else if (!held_q && wait_q == lat)
    begin
      held_q <= 1'b1;
      xfer_done <= 1'b1;
    end
    else
    begin
      wait_q <= held_q ? wait_q : wait_q + 4'h1;
      xfer_done <= 1'b0;
    end
  end
endmodule // dcr_far_model

//--- verif/tb.sv
`include "dcr_consts.svh"
`define CK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb
  import dcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic trig_valid, xfer_done, xfer_req, xfer_byte, xfer_null_wr;
  logic block_event, channel_active;
  logic [7:0] paddr, trig_num;
  logic [31:0] pwdata, prdata, rv;
  logic [23:0] pia_addr, xfer_rd_addr, xfer_wr_addr, base;
  logic [3:0] lat;
  int failures, comparisons, events;
  logic [15:0] fill [8] = '{16'h7FFF, 16'h7FFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  logic [15:0] seen [8] = '{16'h7833, 16'h00FF, 16'h00FF, 16'hFFFF,
    16'h00FF, 16'hFFFF, 16'hFFFF, 16'h3FFF};

  dcr_channel dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trig_valid, .trig_num, .pia_addr, .xfer_done,
    .xfer_req, .xfer_rd_addr, .xfer_wr_addr, .xfer_byte, .xfer_null_wr,
    .block_event, .channel_active
  );
  dcr_far_model far (.pclk, .presetn, .xfer_req, .lat, .xfer_done);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(negedge pclk)
    if (block_event === 1'b1)
      events++;

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
    input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    apb(a, 1'b0, 16'h0000);
    `CK("prdata", {16'h0000, x}, rv)
  endtask

  task automatic trig(input logic [7:0] num);
    trig_valid <= 1'b1;
    trig_num <= num;
    @(posedge pclk);
    trig_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic quiet();
    repeat (6) @(negedge pclk);
    `CK("xfer_req", 1'b0, xfer_req)
    @(posedge pclk);
  endtask

  task automatic xfer(input logic [23:0] r, input logic [23:0] w,
    input logic b, input logic nl);
    @(negedge pclk);
    while (xfer_req !== 1'b1)
      @(negedge pclk);
    `CK("xfer_rd_addr", r, xfer_rd_addr)
    `CK("xfer_wr_addr", w, xfer_wr_addr)
    `CK("xfer_byte", b, xfer_byte)
    `CK("xfer_null_wr", nl, xfer_null_wr)
    while (xfer_req === 1'b1)
      @(negedge pclk);
    @(posedge pclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, trig_valid} = 5'h00;
    {paddr, trig_num, pwdata} = 48'h000000000000;
    pia_addr = 24'h0AB0C0;
    lat = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), 16'h0000);
    `CK("channel_active", 1'b0, channel_active)
    for (int i = 0; i < 8; i++)
    begin
      wr(8'(i * 4), fill[i]);
      rd(8'(i * 4), seen[i]);
    end
    wr(8'h20, 16'hFFFF);
    `CK("pslverr", 1'b1, ev)
    rd(8'h20, 16'h0000);
    rd(`DCR_OFF_CTRL, 16'h7833);
    $display("test registers done");
    wr(`DCR_OFF_CTRL, 16'h0000);
    wr(`DCR_OFF_STAH, 16'h0001);
    wr(`DCR_OFF_STAL, 16'h2340);
    wr(`DCR_OFF_STBH, 16'h0005);
    wr(`DCR_OFF_STBL, 16'h6780);
    wr(`DCR_OFF_PAD, 16'h0ABC);
    wr(`DCR_OFF_CNT, 16'h0001);
    wr(`DCR_OFF_REQ, 16'h002A);
    wr(`DCR_OFF_CTRL, 16'h8003);
    events = 0;
    trig(8'h2B);
    quiet();
    for (int i = 0; i < 4; i++)
    begin
      trig(8'h2A);
      base = (i < 2 ? 24'h012340 : 24'h056780) + 24'(2 * (i % 2));
      xfer(24'h000ABC, base, 1'b0, 1'b0);
    end
    `CK("events", 2, events)
    `CK("channel_active", 1'b0, channel_active)
    trig(8'h2A);
    quiet();
    $display("test ping-pong done");
    wr(`DCR_OFF_CNT, 16'h0003);
    lat <= 4'hF;
    wr(`DCR_OFF_CTRL, 16'hF800);
    events = 0;
    for (int i = 0; i < 5; i++)
    begin
      wr(`DCR_OFF_REQ, 16'h802A);
      if (i == 0)
      begin
        wr(`DCR_OFF_REQ, 16'h002A);
        rd(`DCR_OFF_REQ, 16'h802A);
      end
      base = 24'h012340 + 24'(i % 4);
      xfer(base, 24'h000ABC, 1'b1, 1'b0);
      lat <= 4'h3;
      rd(`DCR_OFF_REQ, 16'h002A);
      if (i == 3)
        rd(`DCR_OFF_STAL, 16'h2343);
    end
    quiet();
    `CK("events", 1, events)
    $display("test forced bytes done");
    for (int m = 1; m < 3; m++)
    begin
      wr(`DCR_OFF_CTRL, 16'h0000);
      wr(`DCR_OFF_CTRL, 16'h8800 | 16'(m << 4));
      base = m == 1 ? 24'h012340 : pia_addr;
      repeat (2)
      begin
        wr(`DCR_OFF_REQ, 16'h802A);
        xfer(24'h000ABC, base, 1'b0, 1'b1);
      end
    end
    $display("test addressing done");
    test_done();
  end
endmodule // tb
